// ===== aux_div_pkg.sv
// Purpose: shared constants and types for the auxiliary lvcmos output dividers
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: register indices are word indices; byte address is four times the index
package aux_div_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SET_W = 8;
  localparam int RATIO_W = 9;

  // register indices
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h2D;
  localparam logic [ADDR_W-1:0] IDX_DIV0 = 8'h2E;
  localparam logic [ADDR_W-1:0] IDX_DIV1 = 8'h2F;
  localparam logic [ADDR_W-1:0] IDX_EDGE = 8'h31;
  localparam logic [ADDR_W-1:0] IDX_SWRST = 8'h32;
  localparam logic [ADDR_W-1:0] IDX_STAT = 8'h33;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h0A;
  localparam logic [SET_W-1:0] DIV_RST = 8'h00;
  localparam logic [3:0] EDGE_RST = 4'h0;

  // control and edge field positions
  localparam int PIN0_SEL_LSB = 0;
  localparam int PIN1_SEL_LSB = 2;
  localparam int PRE_A_LSB = 4;
  localparam int PRE_B_LSB = 6;
  localparam int EDGE1_LSB = 2;

  // two-bit codes and three-bit prescaler ratios
  localparam logic [1:0] SEL_DIV0 = 2'h0;
  localparam logic [1:0] SEL_DIV1 = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV5 = 2'h2;
  localparam logic [2:0] PRE_RATIO4 = 3'h4;
  localparam logic [2:0] PRE_RATIO5 = 3'h5;
  localparam logic [1:0] EDGE_FAST = 2'h0;
  localparam logic [1:0] EDGE_SLOW = 2'h2;

  // divider encoding
  localparam logic [SET_W-1:0] SET_MIN_PLAIN = 8'h06;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 9'h006;

  typedef enum logic [1:0] {
    DIV_STOPPED = 2'b01,
    DIV_RUNNING = 2'b10
  } div_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

endpackage

// ===== aux_div_top.sv
// Purpose: two 8-bit auxiliary clock dividers, pre-dividers, pin muxes and edge-rate fields
// Assumes: synthesizer clocks arrive as one-cycle tick enables on sys_clk_in
// Notes: apb answers with one wait state; pins are output only with active-low enables
//
// How it works
// RULE1: divider 0 is 8-bit, fed by synth a's lvcmos prescaler
// RULE2: divider 1 is 8-bit, fed by synth b's lvcmos prescaler
// RULE3: a setting of zero stops the divider, no output clock
// RULE4: settings six to 255 divide by setting plus one
// RULE5: settings one to five divide by six
// RULE6: divider 1 uses the same ratio encoding as divider 0
// RULE7: host writes the soft reset after re-enabling a stopped divider
// RULE8: pin 0 edge code 0 is fast, 2 is slow; 1 and 3 unused
// RULE9: bits 3:2 hold pin 1 edge code; upper bits reserved
// RULE10: pin mux: 0 divider 0, 1 divider 1, 2 status, 3 off
// RULE11: prescaler code 0 off, 1 divide by 4, 2 divide by 5
// RULE12: stopped divider or silent prescaler holds its output low
`timescale 1ns/1ps
module aux_div_top (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire aux_div_pkg::apb_req_s apb_in,
  output logic [aux_div_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic synth_a_tick_in,
  input wire logic synth_b_tick_in,
  input wire logic aux_pin0_level_in,
  input wire logic aux_pin1_level_in,
  output logic aux_pin0_out,
  output logic aux_pin0_oe_b_out,
  output logic aux_pin0_slow_out,
  output logic aux_pin1_out,
  output logic aux_pin1_oe_b_out,
  output logic aux_pin1_slow_out
);
  import aux_div_pkg::*;

  function automatic logic [RATIO_W-1:0] div_ratio(input logic [SET_W-1:0] s);
    if (s == '0) begin
      return '0;
    end else if (s < SET_MIN_PLAIN) begin
      return RATIO_MIN; // RULE5
    end
    return {1'b0, s} + 9'h001; // RULE4 RULE6
  endfunction

  function automatic logic [2:0] pre_ratio(input logic [1:0] code);
    return (code == PRE_DIV4) ? PRE_RATIO4 : (code == PRE_DIV5) ? PRE_RATIO5 : 3'h0; // RULE11
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
    return {idx[ADDR_W-3:0], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [7:0] ctrl_q;
  logic [SET_W-1:0] set_q [2];
  logic [3:0] edge_q;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic swrst_q;
  logic [1:0] run_st;
  logic [1:0] div_clk_q;

  wire access_w = apb_in.psel & apb_in.penable;
  wire done_w = access_w & pready_q;
  wire hit_ctrl = apb_in.paddr == byte_addr(IDX_CTRL);
  wire hit_div0 = apb_in.paddr == byte_addr(IDX_DIV0);
  wire hit_div1 = apb_in.paddr == byte_addr(IDX_DIV1);
  wire hit_edge = apb_in.paddr == byte_addr(IDX_EDGE);
  wire hit_swrst = apb_in.paddr == byte_addr(IDX_SWRST);
  wire hit_stat = apb_in.paddr == byte_addr(IDX_STAT);
  wire hit_any = hit_ctrl | hit_div0 | hit_div1 | hit_edge | hit_swrst | hit_stat;
  wire wr_w = done_w & apb_in.pwrite & hit_any;
  wire [5:0] stat_w = {aux_pin1_out, aux_pin0_out, div_clk_q, run_st};
  wire [DATA_W-1:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_q} :
    hit_div0 ? {24'h000000, set_q[0]} :
    hit_div1 ? {24'h000000, set_q[1]} :
    hit_edge ? {28'h0000000, edge_q} : // RULE9
    hit_stat ? {26'h0000000, stat_w} : '0;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= access_w & ~pready_q;
      pslverr_q <= access_w & ~pready_q & ~hit_any;
      prdata_q <= (access_w & ~pready_q & ~apb_in.pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= CTRL_RST;
      set_q[0] <= DIV_RST;
      set_q[1] <= DIV_RST;
      edge_q <= EDGE_RST;
      swrst_q <= 1'b0;
    end else begin
      if (wr_w & hit_ctrl) begin
        ctrl_q <= apb_in.pwdata[7:0];
      end
      if (wr_w & hit_div0) begin
        set_q[0] <= apb_in.pwdata[SET_W-1:0]; // RULE1
      end
      if (wr_w & hit_div1) begin
        set_q[1] <= apb_in.pwdata[SET_W-1:0]; // RULE2
      end
      if (wr_w & hit_edge) begin
        edge_q <= apb_in.pwdata[3:0]; // RULE8 RULE9
      end
      swrst_q <= wr_w & hit_swrst & apb_in.pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers and dividers
  wire [1:0] tick_w = {synth_b_tick_in, synth_a_tick_in};
  wire [1:0] pre_code [2];
  assign pre_code[0] = ctrl_q[PRE_A_LSB +: 2];
  assign pre_code[1] = ctrl_q[PRE_B_LSB +: 2];
  logic [1:0] pre_pulse_q;
  logic [RATIO_W-1:0] cnt_q [2];
  wire [RATIO_W-1:0] ratio_w [2];
  div_state_e state_q [2];

  for (genvar i = 0; i < 2; i++) begin : g_div
    logic [2:0] pcnt_q;
    wire [2:0] plim = pre_ratio(pre_code[i]);
    wire pwrap = pcnt_q >= plim - 3'h1;
    assign ratio_w[i] = div_ratio(set_q[i]);
    wire [RATIO_W-1:0] half = ratio_w[i] >> 1;
    wire last = cnt_q[i] >= ratio_w[i] - 9'h001;
    wire [RATIO_W-1:0] cnt_nx = last ? '0 : cnt_q[i] + 9'h001;
    wire live = (state_q[i] == DIV_RUNNING) & (plim != 3'h0);
    assign run_st[i] = state_q[i] == DIV_RUNNING;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        pcnt_q <= '0;
        pre_pulse_q[i] <= 1'b0;
      end else if (plim == 3'h0 || swrst_q) begin
        pcnt_q <= '0; // RULE11
        pre_pulse_q[i] <= 1'b0;
      end else begin
        pre_pulse_q[i] <= tick_w[i] & pwrap;
        if (tick_w[i]) begin
          pcnt_q <= pwrap ? 3'h0 : pcnt_q + 3'h1;
        end
      end
    end

    // a stopped divider only resumes on the soft reset, so both outputs restart in phase
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        state_q[i] <= DIV_STOPPED;
      end else begin
        unique case (state_q[i])
          DIV_STOPPED: begin
            if (swrst_q && set_q[i] != '0) begin
              state_q[i] <= DIV_RUNNING; // RULE7
            end
          end
          DIV_RUNNING: begin
            if (set_q[i] == '0) begin
              state_q[i] <= DIV_STOPPED; // RULE3
            end
          end
        endcase
      end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        cnt_q[i] <= '0;
        div_clk_q[i] <= 1'b0;
      end else if (!live || swrst_q) begin
        cnt_q[i] <= '0;
        div_clk_q[i] <= 1'b0; // RULE12
      end else if (pre_pulse_q[i]) begin
        cnt_q[i] <= cnt_nx; // RULE4 RULE6
        div_clk_q[i] <= cnt_nx < half;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin muxes and edge rate
  wire [1:0] sel0 = ctrl_q[PIN0_SEL_LSB +: 2];
  wire [1:0] sel1 = ctrl_q[PIN1_SEL_LSB +: 2];
  wire [1:0] edge0 = edge_q[1:0];
  wire [1:0] edge1 = edge_q[EDGE1_LSB +: 2];
  wire pin0_d = (sel0 == SEL_DIV0) ? div_clk_q[0] : (sel0 == SEL_DIV1) ? div_clk_q[1] :
    (sel0 == SEL_STATUS) & aux_pin0_level_in;
  wire pin1_d = (sel1 == SEL_DIV0) ? div_clk_q[0] : (sel1 == SEL_DIV1) ? div_clk_q[1] :
    (sel1 == SEL_STATUS) & aux_pin1_level_in;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aux_pin0_out <= 1'b0;
      aux_pin1_out <= 1'b0;
      aux_pin0_oe_b_out <= 1'b1;
      aux_pin1_oe_b_out <= 1'b1;
      aux_pin0_slow_out <= 1'b0;
      aux_pin1_slow_out <= 1'b0;
    end else begin
      aux_pin0_out <= pin0_d; // RULE10
      aux_pin1_out <= pin1_d; // RULE10
      aux_pin0_oe_b_out <= sel0 == SEL_OFF;
      aux_pin1_oe_b_out <= sel1 == SEL_OFF;
      aux_pin0_slow_out <= edge0 == EDGE_SLOW; // RULE8
      aux_pin1_slow_out <= edge1 == EDGE_SLOW; // RULE9
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_zero_stops;
    set_q[0] == '0 |=> state_q[0] == DIV_STOPPED ##1 !div_clk_q[0];
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("divider 0 runs at zero setting"); // RULE3

  property p_low_ratio;
    (set_q[1] != '0 && set_q[1] < SET_MIN_PLAIN) |-> ratio_w[1] == RATIO_MIN;
  endproperty
  a_low_ratio: assert property (p_low_ratio) else $error("divider 1 low ratio not six"); // RULE5

  property p_plain_ratio;
    set_q[0] >= SET_MIN_PLAIN |-> ratio_w[0] == {1'b0, set_q[0]} + 9'h001 && cnt_q[0] < 9'h100;
  endproperty
  a_plain_ratio: assert property (p_plain_ratio) else $error("divider 0 ratio wrong"); // RULE4

  property p_cnt_bound;
    state_q[1] == DIV_RUNNING && set_q[1] == $past(set_q[1]) && $past(pre_pulse_q[1])
      |-> cnt_q[1] < ratio_w[1];
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("divider 1 count past ratio"); // RULE6

  property p_restart;
    swrst_q && set_q[0] != '0 |=> state_q[0] == DIV_RUNNING;
  endproperty
  a_restart: assert property (p_restart) else $error("soft reset did not start divider 0"); // RULE7

  property p_pre_silent;
    pre_code[1] == 2'h0 |=> ##1 !pre_pulse_q[1] && !div_clk_q[1];
  endproperty
  a_pre_silent: assert property (p_pre_silent) else $error("prescaler b active while off"); // RULE11

  property p_pre_spacing;
    pre_pulse_q[0] && pre_code[0] == PRE_DIV4 && $stable(pre_code[0]) |=> !pre_pulse_q[0] [*3];
  endproperty
  a_pre_spacing: assert property (p_pre_spacing) else $error("prescaler a spacing below four"); // RULE11

  property p_mux_div;
    sel0 == SEL_DIV1 |=> aux_pin0_out == $past(div_clk_q[1]) && !aux_pin0_oe_b_out;
  endproperty
  a_mux_div: assert property (p_mux_div) else $error("pin 0 not following divider 1"); // RULE10

  property p_mux_off;
    sel1 == SEL_OFF |=> aux_pin1_oe_b_out && !aux_pin1_out;
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("pin 1 driven while off"); // RULE10

  property p_edge;
    wr_w && hit_edge |=> ##1 aux_pin1_slow_out == ($past(apb_in.pwdata[3:2], 2) == EDGE_SLOW);
  endproperty
  a_edge: assert property (p_edge) else $error("pin 1 edge rate not applied"); // RULE9

  property p_stopped_low;
    state_q[0] == DIV_STOPPED |=> !div_clk_q[0];
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("stopped divider 0 toggles"); // RULE12

  property p_zero_stops1;
    set_q[1] == '0 |=> state_q[1] == DIV_STOPPED ##1 !div_clk_q[1];
  endproperty
  a_zero_stops1: assert property (p_zero_stops1) else $error("divider 1 runs at zero setting"); // RULE3

  property p_stopped_low1;
    state_q[1] == DIV_STOPPED |=> !div_clk_q[1];
  endproperty
  a_stopped_low1: assert property (p_stopped_low1) else $error("stopped divider 1 toggles"); // RULE12

  property p_mux_div0;
    sel1 == SEL_DIV0 |=> aux_pin1_out == $past(div_clk_q[0]) && !aux_pin1_oe_b_out;
  endproperty
  a_mux_div0: assert property (p_mux_div0) else $error("pin 1 not following divider 0"); // RULE10

  property p_edge_fast;
    edge_q[1:0] != EDGE_SLOW |=> !aux_pin0_slow_out;
  endproperty
  a_edge_fast: assert property (p_edge_fast) else $error("pin 0 slow on a fast code"); // RULE8

  c_div0_run: cover property (state_q[0] == DIV_RUNNING ##1 $rose(div_clk_q[0]));
  c_div1_run: cover property (state_q[1] == DIV_RUNNING ##1 $rose(div_clk_q[1]));
  c_slverr: cover property (pslverr_q && pready_q);
  c_pin_status: cover property (sel0 == SEL_STATUS ##1 $rose(aux_pin0_out));

endmodule // aux_div_top

// ===== test_lvcmos_aux_output_dividers.sv
// Purpose: self-checking bench for the auxiliary lvcmos output dividers
// Assumes: apb master per the hand-over contract; byte address is four times the register index
// Notes: synth a ticks every cycle and synth b every other cycle, so pin periods are 4*ratio and 10*ratio
`timescale 1ns/1ps
module test_lvcmos_aux_output_dividers;
  import aux_div_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  apb_req_s apb_q = '0;
  logic synth_a_tick_q = 1'b1;
  logic synth_b_tick_q = 1'b0;
  logic [1:0] level_q = 2'b00;
  logic [DATA_W-1:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [1:0] pin;
  logic [1:0] oe_b;
  logic [1:0] slow;
  logic [DATA_W-1:0] rd;
  logic err;
  logic [3:0] e;
  logic [7:0] sets [5] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'hFF};
  int rats [5] = '{6, 6, 7, 8, 256};
  int miscompares = 0;
  int n_tests = 0;
  aux_div_top u_dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .apb_in(apb_q),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .synth_a_tick_in(synth_a_tick_q), .synth_b_tick_in(synth_b_tick_q),
    .aux_pin0_level_in(level_q[0]), .aux_pin1_level_in(level_q[1]),
    .aux_pin0_out(pin[0]), .aux_pin0_oe_b_out(oe_b[0]), .aux_pin0_slow_out(slow[0]),
    .aux_pin1_out(pin[1]), .aux_pin1_oe_b_out(oe_b[1]), .aux_pin1_slow_out(slow[1])
  );
  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    synth_b_tick_q <= ~synth_b_tick_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge sys_clk_in);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx[5:0], 2'b00}, pwdata: wd};
    @(posedge sys_clk_in);
    apb_q.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    err = pslverr_out;
    if (pready_out !== 1'b1) begin
      check(32'h0, 32'h1);
    end
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
    check({31'h0, err}, 32'h0);
  endtask
  // waits for a fall then a rise on the pin, counting cycles
  task automatic edge_wait(input int p, output int n);
    n = 0;
    while (pin[p] !== 1'b0 && n < 4000) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pin[p] !== 1'b1 && n < 8000) begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask
  // a restart gives a short first period and may leave one stale rise, so three rises are skipped
  task automatic period(input int p, input int exp);
    int n;
    repeat (3) edge_wait(p, n);
    edge_wait(p, n);
    check(DATA_W'(n), DATA_W'(exp));
  endtask
  task automatic quiet(input int p);
    logic bad;
    bad = 1'b0;
    repeat (4) @(posedge sys_clk_in); // the old level drains through up to three register stages first
    repeat (200) begin
      @(posedge sys_clk_in);
      if (pin[p] !== 1'b0 || oe_b[p] !== 1'b0) bad = 1'b1;
    end
    check({31'h0, bad}, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    check(32'h0, 32'h1);
    finish_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rdchk(IDX_CTRL, 32'h0000000A);
    rdchk(IDX_DIV0, 32'h0);
    rdchk(IDX_DIV1, 32'h0);
    rdchk(IDX_EDGE, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    level_q <= 2'b11;
    repeat (3) @(posedge sys_clk_in);
    check({30'h0, pin}, 32'h3);
    check({30'h0, oe_b}, 32'h0);
    level_q <= 2'b01;
    repeat (3) @(posedge sys_clk_in);
    check({30'h0, pin}, 32'h1);
    wr(IDX_CTRL, 32'h0000000F);
    repeat (3) @(posedge sys_clk_in);
    check({30'h0, oe_b}, 32'h3);
    // every edge code on both pins, reserved bits 7:4 written as ones
    for (int c = 0; c < 4; c++) begin
      e = {2'(3 - c), 2'(c)};
      wr(IDX_EDGE, {24'h0, 4'hF, e});
      repeat (2) @(posedge sys_clk_in);
      check({30'h0, slow}, {30'h0, e[3:2] == 2'h2, e[1:0] == 2'h2});
      rdchk(IDX_EDGE, {28'h0, e});
    end
    wr(IDX_CTRL, 32'h00000094);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_DIV0, {24'h0, sets[i]});
      wr(IDX_DIV1, {24'h0, sets[i]});
      wr(IDX_SWRST, 32'h1);
      period(0, 4 * rats[i]);
      period(1, 10 * rats[i]);
    end
    apb(1'b0, IDX_STAT, 32'h0);
    check({30'h0, rd[1:0]}, 32'h3);
    // swap the pins between the dividers
    wr(IDX_CTRL, 32'h00000091);
    wr(IDX_DIV0, 32'h6);
    wr(IDX_DIV1, 32'h6);
    wr(IDX_SWRST, 32'h1);
    period(0, 70);
    period(1, 28);
    wr(IDX_DIV0, 32'h0);
    quiet(1);
    apb(1'b0, IDX_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    wr(IDX_DIV0, 32'h6);
    quiet(1);
    wr(IDX_SWRST, 32'h1);
    period(1, 28);
    wr(IDX_CTRL, 32'h00000081);
    quiet(1);
    wr(IDX_CTRL, 32'h000000B1);
    quiet(1);
    period(0, 70);
    finish_test();
  end
endmodule // test_lvcmos_aux_output_dividers
